// File: dpmm_pkg.sv
// Purpose: shared constants and carriers for the dual-port memory module
// Assumes: 200 MHz module clock
// Notes:   capacity, parity and wrap-around are chosen at build time
package dpmm_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned CYCLE_TIME_PS   = 660000;
  localparam int unsigned CYCLE_CLKS      = (CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACCESS_TIME_PS  = 560000;
  localparam int unsigned ACCESS_CLKS     = ACCESS_TIME_PS / CLK_PERIOD_PS;
  // refresh spacing: every row of a bank revisited in well under 2 ms
  localparam int unsigned REFRESH_TIME_PS = 15000000;
  localparam int unsigned REFRESH_CLKS    = REFRESH_TIME_PS / CLK_PERIOD_PS;
  localparam int unsigned CNT_W           = 12;
  localparam logic [CNT_W-1:0] CYCLE_LAST   = CNT_W'(CYCLE_CLKS - 1);
  localparam logic [CNT_W-1:0] ACCESS_LAST  = CNT_W'(ACCESS_CLKS - 1);
  localparam logic [CNT_W-1:0] REFRESH_LAST = CNT_W'(REFRESH_CLKS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO     = '0;
  localparam logic [CNT_W-1:0] CNT_ONE      = 12'h001;

  localparam int unsigned WORD_W     = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned PAR_W      = 2;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned BANK_ADDR_W = 12;
  localparam int unsigned BANK_SEL_W = ADDR_W - BANK_ADDR_W;
  localparam int unsigned STORE_W    = WORD_W + PAR_W;
  localparam int unsigned ROW_W      = 6;
  localparam logic [ROW_W-1:0] ROW_ONE = 6'h01;

  // capacity in banks of 4,096 words
  localparam logic [BANK_SEL_W:0] BANKS_16K = 5'h04;
  localparam logic [BANK_SEL_W:0] BANKS_32K = 5'h08;
  localparam logic [BANK_SEL_W:0] BANKS_64K = 5'h10;

  typedef enum logic [1:0] {
    DPMM_SIZE_16K = 2'b00,
    DPMM_SIZE_32K = 2'b01,
    DPMM_SIZE_64K = 2'b10
  } dpmm_size_t;

  typedef enum logic [1:0] {
    DPMM_IDLE    = 2'b00,
    DPMM_ACCESS  = 2'b01,
    DPMM_REFRESH = 2'b10
  } dpmm_state_t;

  typedef struct packed {
    logic              req;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } dpmm_port_req_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic [PAR_W-1:0]  parity;
  } dpmm_word_t;
endpackage

// File: dpmm_array.sv
// Purpose: storage array, banks of 4,096 words of data plus byte parity
// Assumes: one access per clock, registered read data
// Notes:   refresh is modelled by the controller's sequencing only
`timescale 1ns/100ps
module dpmm_array (
  input  wire logic                       i_clock,
  input  wire logic                       i_we,
  input  wire logic [dpmm_pkg::ADDR_W-1:0] i_addr,
  input  wire dpmm_pkg::dpmm_word_t       i_wdata,
  output dpmm_pkg::dpmm_word_t            o_rdata
);
  import dpmm_pkg::*;

  dpmm_word_t mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule // dpmm_array

// File: dpmm_module.sv
// Purpose: dual-port dynamic memory module controller with refresh
// Assumes: ports held stable from request until done (processor side)
// Notes:   size, parity and wrap-around are parameters of the build
//
// Functional notes
// - two independent ports A and B, both reading and writing one array.
// - every internal cycle, access or refresh, lasts 660 ns before the next.
// - capacity 16K, 32K or 64K words of 16 bits, address decoded to it.
// - banks of 4,096 words; upper address bits pick the bank.
// - internal refresh sequencer interleaved with port accesses.
// - optional two parity bits per word, one per byte half.
// - wrap-around folds an out-of-range address onto the installed banks, modulo the capacity.
// - without wrap-around, out-of-range reads return zero, writes are dropped.
// - address and control inputs only; data pins bidirectional, driven on reads.
// - largest size drives per-port request outputs to a memory manager.
// - external refresh request input triggers a refresh cycle.
// - only two activities: port access cycles and refresh cycles.
`timescale 1ns/100ps
module dpmm_module #(
  parameter dpmm_pkg::dpmm_size_t SIZE    = dpmm_pkg::DPMM_SIZE_64K,
  parameter bit                   PARITY  = 1'b1,
  parameter bit                   WRAP    = 1'b1
) (
  input  wire logic                          i_clock,
  input  wire logic                          i_resetn,
  input  wire dpmm_pkg::dpmm_port_req_t      i_port_a,
  input  wire dpmm_pkg::dpmm_word_t          i_data_a,
  output dpmm_pkg::dpmm_word_t               o_data_a,
  output logic                               o_data_a_oe,
  output logic                               o_done_a,
  input  wire dpmm_pkg::dpmm_port_req_t      i_port_b,
  input  wire dpmm_pkg::dpmm_word_t          i_data_b,
  output dpmm_pkg::dpmm_word_t               o_data_b,
  output logic                               o_data_b_oe,
  output logic                               o_done_b,
  input  wire logic                          i_refresh_req,
  output logic                               o_mmu_req_a,
  output logic                               o_mmu_req_b
);
  import dpmm_pkg::*;

  // banks installed
  function automatic logic [BANK_SEL_W:0] banks_of(input dpmm_size_t s);
    case (s)
      DPMM_SIZE_16K: banks_of = BANKS_16K;
      DPMM_SIZE_32K: banks_of = BANKS_32K;
      default:       banks_of = BANKS_64K;
    endcase
  endfunction

  localparam logic [BANK_SEL_W:0] BANKS = banks_of(SIZE);

  function automatic logic in_range(input logic [ADDR_W-1:0] a);
    in_range = {1'b0, a[ADDR_W-1:BANK_ADDR_W]} < BANKS;
  endfunction

  // wrap: fold bank select modulo installed banks (power of two)
  function automatic logic [ADDR_W-1:0] map_addr(input logic [ADDR_W-1:0] a);
    logic [BANK_SEL_W-1:0] mask;
    mask     = BANK_SEL_W'(BANKS - 1'b1);
    map_addr = {a[ADDR_W-1:BANK_ADDR_W] & mask, a[BANK_ADDR_W-1:0]};
  endfunction

  // refresh request pin from another domain: three flops, 2nd and 3rd agree
  logic [2:0] rf_sync;
  logic [2:0] next_rf_sync;
  logic       rf_level;
  logic       next_rf_level;
  logic       rf_pend;
  logic       next_rf_pend;
  logic [CNT_W-1:0] rf_timer;
  logic [CNT_W-1:0] next_rf_timer;
  logic [ROW_W-1:0] rf_row;
  logic [ROW_W-1:0] next_rf_row;

  dpmm_state_t state;
  dpmm_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic        sel_b;
  logic        next_sel_b;
  logic        last_b;
  logic        next_last_b;
  logic        cur_write;
  logic        next_cur_write;
  logic        cur_valid;
  logic        next_cur_valid;
  dpmm_word_t  rdata_a;
  dpmm_word_t  next_rdata_a;
  dpmm_word_t  rdata_b;
  dpmm_word_t  next_rdata_b;
  logic        done_a;
  logic        next_done_a;
  logic        done_b;
  logic        next_done_b;
  logic        oe_a;
  logic        next_oe_a;
  logic        oe_b;
  logic        next_oe_b;

  dpmm_port_req_t cur;
  dpmm_word_t     wsrc;
  dpmm_word_t     mem_wdata;
  dpmm_word_t     mem_rdata;
  logic [ADDR_W-1:0] mem_addr;
  logic              mem_we;
  logic              want_a;
  logic              want_b;

  always_comb begin
    next_rf_sync  = {rf_sync[1:0], i_refresh_req};
    next_rf_level = (rf_sync[1] == rf_sync[2]) ? rf_sync[2] : rf_level;
    next_rf_timer = rf_timer;
    next_rf_pend  = rf_pend;
    next_rf_row   = rf_row;
    if (rf_timer == REFRESH_LAST) begin
      next_rf_timer = CNT_ZERO;
    end else begin
      next_rf_timer = rf_timer + CNT_ONE;
    end
    if (state == DPMM_REFRESH && cnt == CYCLE_LAST) begin
      next_rf_pend = 1'b0;
      next_rf_row  = rf_row + ROW_ONE;
    end
    // set wins over the clear above
    if (rf_timer == REFRESH_LAST) begin
      next_rf_pend = 1'b1;
    end
    if (next_rf_level && !rf_level) begin
      next_rf_pend = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rf_sync  <= 3'h0;
      rf_level <= 1'b0;
      rf_pend  <= 1'b0;
      rf_timer <= CNT_ZERO;
      rf_row   <= '0;
    end else begin
      rf_sync  <= next_rf_sync;
      rf_level <= next_rf_level;
      rf_pend  <= next_rf_pend;
      rf_timer <= next_rf_timer;
      rf_row   <= next_rf_row;
    end
  end

  assign cur  = sel_b ? i_port_b : i_port_a;
  assign wsrc = sel_b ? i_data_b : i_data_a;
  // done is registered: in that idle cycle the finished port still shows req
  assign want_a = i_port_a.req && !done_a;
  assign want_b = i_port_b.req && !done_b;

  always_comb begin
    mem_addr  = WRAP ? map_addr(cur.addr) : cur.addr;
    // refresh sweeps the row counter through the array address
    if (state == DPMM_REFRESH) begin
      mem_addr = ADDR_W'(rf_row);
    end
    mem_wdata = wsrc;
    if (!PARITY) begin
      mem_wdata.parity = '0;
    end
    mem_we = (state == DPMM_ACCESS) && (cnt == CNT_ZERO) && cur_write && cur_valid;
  end

  dpmm_array u_array (
    .i_clock (i_clock),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_sel_b     = sel_b;
    next_last_b    = last_b;
    next_cur_write = cur_write;
    next_cur_valid = cur_valid;
    next_rdata_a   = rdata_a;
    next_rdata_b   = rdata_b;
    next_done_a    = 1'b0;
    next_done_b    = 1'b0;
    next_oe_a      = oe_a;
    next_oe_b      = oe_b;
    case (state)
      DPMM_IDLE: begin
        next_cnt = CNT_ZERO;
        if (rf_pend) begin
          next_state = DPMM_REFRESH;
        end else if (want_a || want_b) begin
          // alternate on a tie so neither port starves
          if (want_a && want_b) begin
            next_sel_b = !last_b;
          end else begin
            next_sel_b = want_b;
          end
          next_last_b    = next_sel_b;
          next_cur_write = next_sel_b ? i_port_b.write : i_port_a.write;
          next_cur_valid = WRAP || in_range(next_sel_b ? i_port_b.addr : i_port_a.addr);
          next_state     = DPMM_ACCESS;
        end
      end
      DPMM_ACCESS: begin
        next_cnt = cnt + CNT_ONE;
        if (cnt == ACCESS_LAST && !cur_write) begin
          if (sel_b) begin
            next_rdata_b = cur_valid ? mem_rdata : '0;
            next_oe_b    = 1'b1;
          end else begin
            next_rdata_a = cur_valid ? mem_rdata : '0;
            next_oe_a    = 1'b1;
          end
        end
        if (cnt == CYCLE_LAST) begin
          next_state  = DPMM_IDLE;
          next_done_a = !sel_b;
          next_done_b = sel_b;
        end
      end
      DPMM_REFRESH: begin
        next_cnt = cnt + CNT_ONE;
        if (cnt == CYCLE_LAST) begin
          next_state = DPMM_IDLE;
        end
      end
      default: begin
        next_state = DPMM_IDLE;
      end
    endcase
    // read data driven until the requester drops its request
    if (!i_port_a.req) begin
      next_oe_a = 1'b0;
    end
    if (!i_port_b.req) begin
      next_oe_b = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state     <= DPMM_IDLE;
      cnt       <= CNT_ZERO;
      sel_b     <= 1'b0;
      last_b    <= 1'b0;
      cur_write <= 1'b0;
      cur_valid <= 1'b0;
      rdata_a   <= '0;
      rdata_b   <= '0;
      done_a    <= 1'b0;
      done_b    <= 1'b0;
      oe_a      <= 1'b0;
      oe_b      <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      sel_b     <= next_sel_b;
      last_b    <= next_last_b;
      cur_write <= next_cur_write;
      cur_valid <= next_cur_valid;
      rdata_a   <= next_rdata_a;
      rdata_b   <= next_rdata_b;
      done_a    <= next_done_a;
      done_b    <= next_done_b;
      oe_a      <= next_oe_a;
      oe_b      <= next_oe_b;
    end
  end

  assign o_data_a    = rdata_a;
  assign o_data_b    = rdata_b;
  assign o_data_a_oe = oe_a;
  assign o_data_b_oe = oe_b;
  assign o_done_a    = done_a;
  assign o_done_b    = done_b;
  // only the largest build talks to an external memory manager
  assign o_mmu_req_a = (SIZE == DPMM_SIZE_64K) && i_port_a.req;
  assign o_mmu_req_b = (SIZE == DPMM_SIZE_64K) && i_port_b.req;
endmodule // dpmm_module

// File: dpmm_module_monitor.sv
// Purpose: port-level checker for the dual-port memory module
// Assumes: one clock, async active-low reset, processors hold requests until done
// Notes:   done spacing is judged across both ports; refresh is not visible here
`timescale 1ns/100ps
module dpmm_module_monitor #(
  parameter dpmm_pkg::dpmm_size_t SIZE   = dpmm_pkg::DPMM_SIZE_64K,
  parameter bit                   PARITY = 1'b1,
  parameter bit                   WRAP   = 1'b1
) (
  input wire logic                     i_clock,
  input wire logic                     i_resetn,
  input wire dpmm_pkg::dpmm_port_req_t i_port_a,
  input wire dpmm_pkg::dpmm_word_t     i_data_a,
  input wire dpmm_pkg::dpmm_word_t     o_data_a,
  input wire logic                     o_data_a_oe,
  input wire logic                     o_done_a,
  input wire dpmm_pkg::dpmm_port_req_t i_port_b,
  input wire dpmm_pkg::dpmm_word_t     i_data_b,
  input wire dpmm_pkg::dpmm_word_t     o_data_b,
  input wire logic                     o_data_b_oe,
  input wire logic                     o_done_b,
  input wire logic                     i_refresh_req,
  input wire logic                     o_mmu_req_a,
  input wire logic                     o_mmu_req_b
);
  import dpmm_pkg::*;
  localparam bit BIG   = (SIZE == DPMM_SIZE_64K);
  localparam int BANKS = 4 << int'(SIZE);
  // saturates so a long idle spell cannot wrap into a false short gap
  logic [7:0] gap;
  logic [7:0] next_gap;
  always_comb next_gap = (o_done_a || o_done_b) ? 8'h00 : ((gap == 8'hff) ? gap : gap + 8'h01);
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) gap <= 8'hff;
    else gap <= next_gap;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  done_cause_a: assert property (o_done_a |-> $past(i_port_a.req, 133))
    else $error("port a done without a full cycle of request");
  b_done_cause_a: assert property (o_done_b |-> $past(i_port_b.req, 133))
    else $error("port b done without a full cycle of request");
  done_pulse_a: assert property (o_done_a |=> !o_done_a)
    else $error("port a done longer than one cycle");
  cycle_gap_a: assert property ((o_done_a || o_done_b) |-> gap >= 8'h83)
    else $error("two cycles closer than the cycle time");
  done_excl_a: assert property (!(o_done_a && o_done_b))
    else $error("both ports finished together");
  read_drive_a: assert property ($rose(o_data_a_oe) |-> i_port_a.req && !i_port_a.write)
    else $error("port a data driven outside a read");
  oe_release_a: assert property (!i_port_a.req ##1 !i_port_a.req |-> !o_data_a_oe)
    else $error("port a data still driven after release");
  access_time_a: assert property ($rose(o_data_a_oe) |-> ##[20:21] o_done_a)
    else $error("port a read data not ahead of done by the access time");
  mmu_tie_a: assert property (o_mmu_req_a == (BIG && i_port_a.req))
    else $error("port a manager request wrong");
  b_mmu_tie_a: assert property (o_mmu_req_b == (BIG && i_port_b.req))
    else $error("port b manager request wrong");
  oor_zero_a: assert property (o_data_a_oe && !WRAP && (int'(i_port_a.addr[15:12]) >= BANKS)
    |-> o_data_a.data == 16'h0000)
    else $error("out-of-range read not zero");
  par_zero_a: assert property (o_data_a_oe && !PARITY |-> o_data_a.parity == 2'h0)
    else $error("parity returned without parity storage");
endmodule // dpmm_module_monitor
bind dpmm_module dpmm_module_monitor #(.SIZE(SIZE), .PARITY(PARITY), .WRAP(WRAP))
  dpmm_module_monitor_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_port_a(i_port_a),
  .i_data_a(i_data_a), .o_data_a(o_data_a), .o_data_a_oe(o_data_a_oe), .o_done_a(o_done_a),
  .i_port_b(i_port_b), .i_data_b(i_data_b), .o_data_b(o_data_b), .o_data_b_oe(o_data_b_oe),
  .o_done_b(o_done_b), .i_refresh_req(i_refresh_req), .o_mmu_req_a(o_mmu_req_a),
  .o_mmu_req_b(o_mmu_req_b));

// File: dpmm_proc_model.sv
// Purpose: processor on one memory bus port
// Assumes: one request at a time, started by a go pulse
// Notes:   idle data lines toggle so a stale value is never mistaken for data
`timescale 1ns/100ps
module dpmm_proc_model (
  input  wire logic                 i_clock,
  input  wire logic                 i_resetn,
  input  wire logic                 i_go,
  input  wire logic                 i_write,
  input  wire logic [15:0]          i_addr,
  input  wire logic [15:0]          i_wdata,
  input  wire logic                 i_done,
  input  wire dpmm_pkg::dpmm_word_t i_rdata,
  output dpmm_pkg::dpmm_port_req_t  o_port,
  output dpmm_pkg::dpmm_word_t      o_data,
  output dpmm_pkg::dpmm_word_t      o_rword,
  output logic                      o_busy
);
  import dpmm_pkg::*;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_port  <= '0;
      o_data  <= '0;
      o_rword <= '0;
      o_busy  <= 1'b0;
    end else if (!o_busy && i_go) begin
      o_port <= '{req: 1'b1, write: i_write, addr: i_addr};
      o_data <= i_write ? {i_wdata, ^i_wdata[15:8], ^i_wdata[7:0]} : ~o_data;
      o_busy <= 1'b1;
    end else if (o_busy && i_done) begin
      o_port.req <= 1'b0;
      o_rword    <= i_rdata;
      o_busy     <= 1'b0;
    end else if (!o_port.write || !o_busy) begin
      o_data <= ~o_data;
    end
  end
endmodule // dpmm_proc_model

// File: dpmm_module_tb_top.sv
// Purpose: testbench for the dual-port memory module
// Assumes: three builds share the same processors and run in lockstep
// Notes:   second build is 32K without wrap-around or parity
`timescale 1ns/100ps
module dpmm_module_tb_top;
  import dpmm_pkg::*;
  logic           i_clock       = 1'b0;
  logic           i_resetn      = 1'b0;
  logic           i_refresh_req = 1'b0;
  logic [1:0]     go            = 2'b00;
  logic [1:0]     wr            = 2'b00;
  logic [15:0]    ad [2]        = '{16'h0000, 16'h0000};
  logic [15:0]    wd [2]        = '{16'h0000, 16'h0000};
  dpmm_port_req_t port [2];
  dpmm_word_t     wdat [2];
  dpmm_word_t     q1 [2];
  dpmm_word_t     q2 [2];
  dpmm_word_t     rw [2];
  dpmm_word_t     cap2 [2];
  logic [1:0]     oe1;
  logic [1:0]     dn1;
  logic [1:0]     busy;
  logic [1:0]     mmu;
  logic [1:0]     mmu1;
  int             fails = 0;
  int             tests_run = 0;
  always #2.5 i_clock = ~i_clock;
  dpmm_proc_model dpmm_proc_model_inst_a (.i_clock(i_clock), .i_resetn(i_resetn), .i_go(go[0]),
    .i_write(wr[0]), .i_addr(ad[0]), .i_wdata(wd[0]), .i_done(dn1[0]), .i_rdata(q1[0]),
    .o_port(port[0]), .o_data(wdat[0]), .o_rword(rw[0]), .o_busy(busy[0]));
  dpmm_proc_model dpmm_proc_model_inst_b (.i_clock(i_clock), .i_resetn(i_resetn), .i_go(go[1]),
    .i_write(wr[1]), .i_addr(ad[1]), .i_wdata(wd[1]), .i_done(dn1[1]), .i_rdata(q1[1]),
    .o_port(port[1]), .o_data(wdat[1]), .o_rword(rw[1]), .o_busy(busy[1]));
  dpmm_module #(.SIZE(DPMM_SIZE_16K), .PARITY(1'b1), .WRAP(1'b1)) dpmm_module_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_refresh_req(i_refresh_req),
    .i_port_a(port[0]), .i_data_a(wdat[0]), .o_data_a(q1[0]), .o_data_a_oe(oe1[0]),
    .o_done_a(dn1[0]), .i_port_b(port[1]), .i_data_b(wdat[1]), .o_data_b(q1[1]),
    .o_data_b_oe(oe1[1]), .o_done_b(dn1[1]), .o_mmu_req_a(mmu1[0]), .o_mmu_req_b(mmu1[1]));
  dpmm_module #(.SIZE(DPMM_SIZE_32K), .PARITY(1'b0), .WRAP(1'b0)) dpmm_module_inst_b (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_refresh_req(i_refresh_req),
    .i_port_a(port[0]), .i_data_a(wdat[0]), .o_data_a(q2[0]), .o_data_a_oe(),
    .o_done_a(), .i_port_b(port[1]), .i_data_b(wdat[1]), .o_data_b(q2[1]),
    .o_data_b_oe(), .o_done_b(), .o_mmu_req_a(), .o_mmu_req_b());
  // largest build, only for its manager request outputs
  dpmm_module #(.SIZE(DPMM_SIZE_64K), .PARITY(1'b1), .WRAP(1'b0)) dpmm_module_inst_c (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_refresh_req(i_refresh_req),
    .i_port_a(port[0]), .i_data_a(wdat[0]), .o_data_a(), .o_data_a_oe(),
    .o_done_a(), .i_port_b(port[1]), .i_data_b(wdat[1]), .o_data_b(),
    .o_data_b_oe(), .o_done_b(), .o_mmu_req_a(mmu[0]), .o_mmu_req_b(mmu[1]));
  // second build finishes in step with the first, so its done is not needed
  always @(posedge i_clock) begin
    if (dn1[0]) cap2[0] <= q2[0];
    if (dn1[1]) cap2[1] <= q2[1];
  end
  function automatic logic [17:0] pw(input logic [15:0] d);
    return {d, ^d[15:8], ^d[7:0]};
  endfunction
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic test_done();
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic [1:0] m, input logic w, input logic [15:0] a, d,
                      output int n, output int f);
    n = 0;
    f = -1;
    @(posedge i_clock);
    go <= m;
    wr <= {w, w};
    ad <= '{a, a};
    wd <= '{d, d};
    @(posedge i_clock);
    go <= 2'b00;
    do begin
      @(posedge i_clock);
      #1;
      n++;
      if (f < 0 && busy[0] !== busy[1]) f = busy[0] ? 1 : 0;
      if (n == 1) chk("manager request", {16'h0, m}, {16'h0, mmu});
      if (n == 1) chk("small build manager request", 18'h0, {16'h0, mmu1});
    end while ((busy & m) !== 2'b00 && n < 700);
    chk("handshake wait", 18'h0, {17'h0, n >= 700});
    chk("manager release", 18'h0, {16'h0, mmu});
  endtask
  task automatic wrt(input int p, input logic [15:0] a, d);
    int n, f;
    xfer(2'b01 << p, 1'b1, a, d, n, f);
  endtask
  task automatic rd(input int p, input logic [15:0] a, e1, e2);
    int n, f;
    xfer(2'b01 << p, 1'b0, a, 16'h0000, n, f);
    chk("read word", pw(e1), rw[p]);
    chk("read word no parity", {e2, 2'b00}, cap2[p]);
  endtask
  task automatic t_basic();
    wrt(0, 16'h0123, 16'ha55a);
    rd(1, 16'h0123, 16'ha55a, 16'ha55a);
  endtask
  task automatic t_banks();
    for (int i = 0; i < 4; i++) wrt(i % 2, {i[3:0], 12'h005}, 16'h3c00 + 16'(i));
    for (int i = 0; i < 4; i++) rd(1 - i % 2, {i[3:0], 12'h005}, 16'h3c00 + 16'(i),
                                   16'h3c00 + 16'(i));
  endtask
  task automatic t_wrap();
    wrt(0, 16'h4005, 16'h7e81);
    wrt(1, 16'h8005, 16'h0bd4);
    rd(0, 16'h8005, 16'h0bd4, 16'h0000);
    rd(1, 16'h0005, 16'h0bd4, 16'h3c00);
    rd(0, 16'h4005, 16'h0bd4, 16'h7e81);
  endtask
  task automatic t_tie();
    int n, f;
    xfer(2'b11, 1'b1, 16'h0777, 16'h5aa5, n, f);
    chk("tie first finisher", 18'h1, 18'(f));
    chk("tie span", 18'h1, {17'h0, n >= 264});
    // a b-only grant first, so the next tie goes to a
    rd(1, 16'h0777, 16'h5aa5, 16'h5aa5);
    xfer(2'b11, 1'b0, 16'h0777, 16'h0000, n, f);
    chk("tie alternation", 18'h0, 18'(f));
    chk("tie read", pw(16'h5aa5), rw[1]);
  endtask
  task automatic t_refresh();
    int n, f;
    @(posedge i_clock);
    i_refresh_req <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_refresh_req <= 1'b0;
    xfer(2'b01, 1'b0, 16'h0123, 16'h0000, n, f);
    chk("refresh delays access", 18'h1, {17'h0, n >= 250});
    chk("data after refresh", pw(16'ha55a), rw[0]);
  endtask
  task automatic t_retain();
    repeat (3100) @(posedge i_clock);
    rd(1, 16'h2005, 16'h3c02, 16'h3c02);
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_basic();
    t_banks();
    t_wrap();
    t_tie();
    t_refresh();
    t_retain();
    test_done();
  end
  // about 25 transfers plus a long idle spell fit well inside this
  initial begin
    repeat (40000) @(posedge i_clock);
    fails++;
    test_done();
  end
endmodule // dpmm_module_tb_top
